// *** core/hfl_top.sv ***
/*
  fifo level thresholds, byte order word and receive readout control.
  assumes fifo levels and readout strobes come from logic on core_clk_in,
  and a host master on the strobe register port that never waits.
*/
// Decided for this implementation: strobed register access.
`timescale 1ns/1ns
module hfl_top
  import hfl_pkg::*;
#(
  parameter int LVL_W = 9
)
(
  // clock and reset
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  // fifo levels
  input wire logic [LVL_W-1:0] tx_data_free_blocks_in,
  input wire logic [LVL_W-1:0] tx_status_used_in,
  input wire logic [LVL_W-1:0] rx_status_used_in,
  // receive readout
  input wire logic rx_pkt_start_in,
  input wire logic rx_read_dword_in,
  input wire logic rx_last_data_in,
  output logic rx_discard_out,
  output logic [2:0] rx_pad_dwords_out,
  output logic rx_pad_valid_out,
  output logic [1:0] rx_offset_bytes_out,
  output logic [2:0] rx_offset_dwords_out,
  // interrupt
  output logic irq_out
);
  // ==========================================================
  // reset and decode
  logic rst_n;
  logic wr_thr;
  logic wr_cfg;
  logic wr_sts;
  logic wr_en;

  hfl_rst_sync u_rst
  (
    .clk_in(core_clk_in),
    .reset_n_in(reset_n_in),
    .reset_n_out(rst_n)
  );

  assign wr_thr = reg_wr_in && (reg_addr_in == OFS_FIFO_LEVEL);
  assign wr_cfg = reg_wr_in && (reg_addr_in == OFS_RX_READOUT);
  assign wr_sts = reg_wr_in && (reg_addr_in == OFS_INT_STATUS);
  assign wr_en = reg_wr_in && (reg_addr_in == OFS_INT_ENABLE);

  // ==========================================================
  // fifo level thresholds
  logic [7:0] txspace_thr_q;
  logic [7:0] txstat_thr_q;
  logic [7:0] rxstat_thr_q;

  always_ff @(posedge core_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      txspace_thr_q <= TXSPACE_RST;
      txstat_thr_q <= TXSTAT_RST;
      rxstat_thr_q <= RXSTAT_RST;
    end
    else if (wr_thr)
    begin
      txspace_thr_q <= reg_wdata_in[TXSPACE_LSB +: THR_W];
      txstat_thr_q <= reg_wdata_in[TXSTAT_LSB +: THR_W];
      rxstat_thr_q <= reg_wdata_in[RXSTAT_LSB +: THR_W];
    end
  end

  logic txspace_above;
  logic txstat_above;
  logic rxstat_above;

  hfl_level_cmp #(.LVL_W(LVL_W), .THR_W(THR_W)) u_cmp_txspace
  (
    .clk_in(core_clk_in),
    .reset_n_in(rst_n),
    .level_in(tx_data_free_blocks_in),
    .threshold_in(txspace_thr_q),
    .above_out(txspace_above)
  );

  hfl_level_cmp #(.LVL_W(LVL_W), .THR_W(THR_W)) u_cmp_txstat
  (
    .clk_in(core_clk_in),
    .reset_n_in(rst_n),
    .level_in(tx_status_used_in),
    .threshold_in(txstat_thr_q),
    .above_out(txstat_above)
  );

  hfl_level_cmp #(.LVL_W(LVL_W), .THR_W(THR_W)) u_cmp_rxstat
  (
    .clk_in(core_clk_in),
    .reset_n_in(rst_n),
    .level_in(rx_status_used_in),
    .threshold_in(rxstat_thr_q),
    .above_out(rxstat_above)
  );

  // ==========================================================
  // receive readout configuration
  logic [1:0] align_cfg_q;
  logic [11:0] cnt_q;
  logic [4:0] offset_q;
  logic rx_done_evt;

  always_ff @(posedge core_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      align_cfg_q <= HFL_ALIGN_4;
      offset_q <= OFFSET_RST;
    end
    else if (wr_cfg)
    begin
      align_cfg_q <= reg_wdata_in[ALIGN_LSB +: 2];
      offset_q <= reg_wdata_in[OFFSET_LSB +: OFFSET_W];
    end
  end

  // a host rewrite beats the decrement in the same cycle
  always_ff @(posedge core_clk_in or negedge rst_n)
  begin
    if (!rst_n)
      cnt_q <= CNT_RST;
    else if (wr_cfg)
      cnt_q <= reg_wdata_in[CNT_LSB +: CNT_W];
    else if (rx_read_dword_in && (cnt_q != CNT_RST))
      cnt_q <= cnt_q - 12'h001;
  end

  assign rx_done_evt = !wr_cfg && rx_read_dword_in && (cnt_q == 12'h001);

  // discard strobe: the bit itself never holds a one
  always_ff @(posedge core_clk_in or negedge rst_n)
  begin
    if (!rst_n)
      rx_discard_out <= 1'b0;
    else
      rx_discard_out <= wr_cfg && reg_wdata_in[DISCARD_BIT];
  end

  // low offset bits are taken as written; host keeps them still while running
  always_ff @(posedge core_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_offset_bytes_out <= 2'b00;
      rx_offset_dwords_out <= 3'h0;
    end
    else
    begin
      rx_offset_bytes_out <= offset_q[1:0];
      if (rx_read_dword_in)
        rx_offset_dwords_out <= offset_q[4:2];
    end
  end

  // ==========================================================
  // end-of-buffer padding
  logic [2:0] pos_q;
  logic [2:0] pkt_mask_q;
  logic [2:0] cfg_mask;

  always_comb
  begin
    unique case (hfl_align_type'(align_cfg_q))
      HFL_ALIGN_4: cfg_mask = MASK_4;
      HFL_ALIGN_16: cfg_mask = MASK_16;
      HFL_ALIGN_32: cfg_mask = MASK_32;
      HFL_ALIGN_RSVD: cfg_mask = MASK_4;
    endcase
  end

  // alignment is frozen per packet so a late write cannot tear a buffer
  always_ff @(posedge core_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pos_q <= 3'h0;
      pkt_mask_q <= MASK_4;
    end
    else if (rx_pkt_start_in || rx_discard_out)
    begin
      pos_q <= 3'h0;
      pkt_mask_q <= cfg_mask;
    end
    else if (rx_read_dword_in)
      pos_q <= pos_q + 3'h1;
  end

  always_ff @(posedge core_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_pad_valid_out <= 1'b0;
      rx_pad_dwords_out <= 3'h0;
    end
    else
    begin
      rx_pad_valid_out <= rx_read_dword_in && rx_last_data_in;
      if (rx_read_dword_in && rx_last_data_in)
        rx_pad_dwords_out <= ~pos_q & pkt_mask_q;
    end
  end

  // ==========================================================
  // interrupt status and enable
  logic [31:0] sts_q;
  logic [31:0] en_q;
  logic [31:0] sts_set;

  always_comb
  begin
    sts_set = 32'h0000_0000;
    sts_set[IRQ_TXSPACE_BIT] = txspace_above;
    sts_set[IRQ_TXSTAT_BIT] = txstat_above;
    sts_set[IRQ_RXSTAT_BIT] = rxstat_above;
    sts_set[IRQ_RXDONE_BIT] = rx_done_evt;
  end

  // a set in the clearing cycle survives
  always_ff @(posedge core_clk_in or negedge rst_n)
  begin
    if (!rst_n)
      sts_q <= 32'h0000_0000;
    else if (wr_sts)
      sts_q <= (sts_q & ~reg_wdata_in) | sts_set;
    else
      sts_q <= sts_q | sts_set;
  end

  always_ff @(posedge core_clk_in or negedge rst_n)
  begin
    if (!rst_n)
      en_q <= 32'h0000_0000;
    else if (wr_en)
      en_q <= reg_wdata_in & IRQ_IMPL_MASK;
  end

  always_ff @(posedge core_clk_in or negedge rst_n)
  begin
    if (!rst_n)
      irq_out <= 1'b0;
    else
      irq_out <= |(sts_q & en_q);
  end

  // ==========================================================
  // read port
  logic [31:0] rd_mux;

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    unique case (reg_addr_in)
      OFS_BYTE_ORDER: rd_mux = BYTE_ORDER_WORD;
      OFS_FIFO_LEVEL:
        rd_mux = {txspace_thr_q, txstat_thr_q, 8'h00, rxstat_thr_q};
      OFS_RX_READOUT:
        rd_mux = {align_cfg_q, 2'b00, cnt_q, 1'b0, 2'b00, offset_q, 8'h00};
      OFS_INT_STATUS: rd_mux = sts_q;
      OFS_INT_ENABLE: rd_mux = en_q;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk_in or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata_out <= 32'h0000_0000;
    else if (reg_rd_in)
      reg_rdata_out <= rd_mux;
    else
      reg_rdata_out <= 32'h0000_0000;
  end

  // ==========================================================
  // checks
  a_byte_order_read: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    reg_rd_in && reg_addr_in == OFS_BYTE_ORDER |=> reg_rdata_out == 32'h8765_4321)
    else $error("byte order word wrong");

  a_txspace_sets: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    tx_data_free_blocks_in > LVL_W'(txspace_thr_q) && !wr_thr
      |=> ##1 sts_q[IRQ_TXSPACE_BIT])
    else $error("tx space status not set");

  a_rxstat_quiet: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    $rose(sts_q[IRQ_RXSTAT_BIT]) |-> $past(rxstat_above))
    else $error("rx status level set without cause");

  a_count_decrement: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    rx_read_dword_in && !wr_cfg && cnt_q != 12'h000
      |=> cnt_q == $past(cnt_q) - 12'h001)
    else $error("countdown did not decrement");

  a_count_rewrite: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    wr_cfg |=> cnt_q == $past(reg_wdata_in[CNT_LSB +: CNT_W]))
    else $error("countdown rewrite lost");

  a_done_status: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    rx_read_dword_in && !wr_cfg && cnt_q == 12'h001
      |=> cnt_q == 12'h000 && sts_q[IRQ_RXDONE_BIT])
    else $error("done status missing");

  // a second discard write right behind the first keeps the strobe up one more cycle
  a_discard_pulse: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    wr_cfg && reg_wdata_in[DISCARD_BIT]
      |=> rx_discard_out ##1 (!rx_discard_out || $past(wr_cfg && reg_wdata_in[DISCARD_BIT])))
    else $error("discard strobe wrong");

  a_pad_sixteen: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    rx_read_dword_in && rx_last_data_in && pkt_mask_q == 3'h3 && pos_q == 3'h0
      |=> rx_pad_valid_out && rx_pad_dwords_out == 3'h3)
    else $error("16-byte pad count wrong");

  a_irq_gated: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    (sts_q & en_q) == 32'h0000_0000 |=> !irq_out)
    else $error("interrupt without enabled status");

  a_w1c_clear: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    wr_sts && reg_wdata_in[IRQ_TXSPACE_BIT] && !txspace_above |=> !sts_q[IRQ_TXSPACE_BIT])
    else $error("write one did not clear");

  c_done_irq: cover property (@(posedge core_clk_in) disable iff (!rst_n)
    rx_done_evt ##2 irq_out);
  c_pad_32: cover property (@(posedge core_clk_in) disable iff (!rst_n)
    rx_pad_valid_out && rx_pad_dwords_out == 3'h7);
  c_discard: cover property (@(posedge core_clk_in) disable iff (!rst_n)
    rx_discard_out);
  c_txspace: cover property (@(posedge core_clk_in) disable iff (!rst_n)
    $rose(sts_q[IRQ_TXSPACE_BIT]));
endmodule

// *** core/hfl_pkg.sv ***
/*
  constants, register map and field layout of the fifo level and receive
  readout configuration block.
  assumes a single core clock and a plain strobe register port.
*/
package hfl_pkg;
  // ==========================================================
  // register map
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_INT_STATUS = 8'h58;
  localparam logic [7:0] OFS_INT_ENABLE = 8'h5c;
  localparam logic [7:0] OFS_BYTE_ORDER = 8'h64;
  localparam logic [7:0] OFS_FIFO_LEVEL = 8'h68;
  localparam logic [7:0] OFS_RX_READOUT = 8'h6c;
  localparam logic [31:0] BYTE_ORDER_WORD = 32'h8765_4321;

  // ==========================================================
  // fifo level threshold fields
  localparam int TXSPACE_LSB = 24;
  localparam int TXSTAT_LSB = 16;
  localparam int RXSTAT_LSB = 0;
  localparam int THR_W = 8;
  localparam logic [7:0] TXSPACE_RST = 8'h48;
  localparam logic [7:0] TXSTAT_RST = 8'h00;
  localparam logic [7:0] RXSTAT_RST = 8'h00;

  // ==========================================================
  // receive readout fields
  localparam int ALIGN_LSB = 30;
  localparam int CNT_LSB = 16;
  localparam int CNT_W = 12;
  localparam int DISCARD_BIT = 15;
  localparam int OFFSET_LSB = 8;
  localparam int OFFSET_W = 5;
  localparam logic [11:0] CNT_RST = 12'h000;
  localparam logic [4:0] OFFSET_RST = 5'h00;

  typedef enum logic [1:0] {
    HFL_ALIGN_4 = 2'b00,
    HFL_ALIGN_16 = 2'b01,
    HFL_ALIGN_32 = 2'b10,
    HFL_ALIGN_RSVD = 2'b11
  } hfl_align_type;

  // dword position masks for each alignment
  localparam int POS_W = 3;
  localparam logic [2:0] MASK_4 = 3'h0;
  localparam logic [2:0] MASK_16 = 3'h3;
  localparam logic [2:0] MASK_32 = 3'h7;

  // ==========================================================
  // interrupt status / enable bits
  localparam int IRQ_RXSTAT_BIT = 3;
  localparam int IRQ_TXSTAT_BIT = 7;
  localparam int IRQ_TXSPACE_BIT = 9;
  localparam int IRQ_RXDONE_BIT = 20;
  localparam logic [31:0] IRQ_IMPL_MASK = 32'h0010_0288;
endpackage

// *** core/hfl_rst_sync.sv ***
/*
  reset release synchroniser.
  assumes an asynchronous active-low reset from a pin.
*/
`timescale 1ns/1ns
module hfl_rst_sync
(
  // clock and raw reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // synchronised reset
  output logic reset_n_out
);
  logic stage_q;

  // assertion is immediate, release waits two edges
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      stage_q <= 1'b0;
      reset_n_out <= 1'b0;
    end
    else
    begin
      stage_q <= 1'b1;
      reset_n_out <= stage_q;
    end
  end
endmodule

// *** core/hfl_level_cmp.sv ***
/*
  registered "level above threshold" comparator.
  assumes level and threshold come from logic on the same clock.
*/
`timescale 1ns/1ns
module hfl_level_cmp
#(
  parameter int LVL_W = 9,
  parameter int THR_W = 8
)
(
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // operands
  input wire logic [LVL_W-1:0] level_in,
  input wire logic [THR_W-1:0] threshold_in,
  // result
  output logic above_out
);
  logic [LVL_W-1:0] thr_ext;

  assign thr_ext = LVL_W'(threshold_in);

  // strictly greater than: equal to the threshold does not fire
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      above_out <= 1'b0;
    else
      above_out <= (level_in > thr_ext);
  end
endmodule

// *** testbench/hfl_host_model.sv ***
/*
  host processor model: master of the strobe register port.
  assumes the slave never waits and answers a read in the next cycle.
*/
`timescale 1ns/1ns
module hfl_host_model
  import hfl_pkg::*;
(
  // clock
  input wire logic clk_in,
  // register port
  output logic [ADDR_W-1:0] addr_out,
  output logic [31:0] wdata_out,
  output logic wr_out,
  output logic rd_out,
  input wire logic [31:0] rdata_in
);
  initial
  begin
    addr_out = 8'h00;
    wdata_out = 32'h0000_0000;
    wr_out = 1'b0;
    rd_out = 1'b0;
  end

  // ==========================================================
  // bus cycles
  // released lines show the inverse so stale values never match
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_in);
    addr_out <= a;
    wdata_out <= v;
    wr_out <= 1'b1;
    @(posedge clk_in);
    wr_out <= 1'b0;
    addr_out <= ~a;
    wdata_out <= ~v;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_in);
    addr_out <= a;
    rd_out <= 1'b1;
    @(posedge clk_in);
    rd_out <= 1'b0;
    addr_out <= ~a;
    @(negedge clk_in);
    v = rdata_in;
  endtask
endmodule

// *** testbench/host_fifo_level_and_rx_readout_cfg_test.sv ***
/*
  self-checking bench: host model on the register port, random fifo
  levels and readout strobes driven here.
  assumes the design package and a 100 MHz core clock.
*/
`timescale 1ns/1ns
module host_fifo_level_and_rx_readout_cfg_test
  import hfl_pkg::*;
;
  logic clk, rst_n, wr, rd, pkt, rd_dw, rd_last, disc, pad_v, irq;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, d, thr, en, w;
  logic [8:0] lv_a, lv_b, lv_c;
  logic [2:0] pad, off_dw, prev_dw;
  logic [1:0] off_b;
  int bad_count, tests_run, n, seed;

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  hfl_host_model host (.clk_in(clk), .addr_out(addr), .wdata_out(wdata), .wr_out(wr),
    .rd_out(rd), .rdata_in(rdata));

  hfl_top #(.LVL_W(9)) DUT (.core_clk_in(clk), .reset_n_in(rst_n), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
    .tx_data_free_blocks_in(lv_a), .tx_status_used_in(lv_b), .rx_status_used_in(lv_c),
    .rx_pkt_start_in(pkt), .rx_read_dword_in(rd_dw), .rx_last_data_in(rd_last),
    .rx_discard_out(disc), .rx_pad_dwords_out(pad), .rx_pad_valid_out(pad_v),
    .rx_offset_bytes_out(off_b), .rx_offset_dwords_out(off_dw), .irq_out(irq));

  // ==========================================================
  // helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic dwords(input int cnt, input logic last);
    for (int i = 0; i < cnt; i++)
    begin
      @(posedge clk);
      rd_dw <= 1'b1;
      rd_last <= last && (i == cnt - 1);
    end
    @(posedge clk);
    rd_dw <= 1'b0;
    rd_last <= 1'b0;
  endtask

  // strict compare: a level equal to its threshold must stay quiet
  function automatic logic [31:0] lvl_sts(input logic [31:0] t);
    logic [31:0] s;
    s = 32'h0000_0000;
    s[IRQ_TXSPACE_BIT] = lv_a > {1'b0, t[31:24]};
    s[IRQ_TXSTAT_BIT] = lv_b > {1'b0, t[23:16]};
    s[IRQ_RXSTAT_BIT] = lv_c > {1'b0, t[7:0]};
    return s;
  endfunction

  // filler up to 4, 8 or 1 dwords; reserved code behaves as 4-byte
  function automatic logic [2:0] pad_exp(input int al, input int cnt);
    logic [2:0] m;
    m = (al == 1) ? 3'h3 : (al == 2) ? 3'h7 : 3'h0;
    return 3'(8 - cnt % 8) & m;
  endfunction

  initial
  begin
    #200000;
    bad_count++;
    tally_and_finish();
  end

  // ==========================================================
  // main sequence
  initial
  begin
    seed = $urandom(65);
    rst_n = 1'b0;
    {pkt, rd_dw, rd_last} = 3'h0;
    {lv_a, lv_b, lv_c} = 27'h0;
    bad_count = 0;
    tests_run = 0;
    prev_dw = 3'h0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    host.rd(OFS_BYTE_ORDER, d);
    check(d, BYTE_ORDER_WORD);
    host.wr(OFS_BYTE_ORDER, 32'h0000_0000);
    host.rd(OFS_BYTE_ORDER, d);
    check(d, BYTE_ORDER_WORD);
    host.rd(OFS_FIFO_LEVEL, d);
    check(d, 32'h4800_0000);
    host.rd(OFS_RX_READOUT, d);
    check(d, 32'h0000_0000);
    host.rd(8'h60, d);
    check(d, 32'h0000_0000);
    $display("reset values done");
    for (int i = 0; i < 12; i++)
    begin
      thr = $urandom;
      en = $urandom & IRQ_IMPL_MASK;
      host.wr(OFS_FIFO_LEVEL, thr);
      host.rd(OFS_FIFO_LEVEL, d);
      check(d, thr & 32'hffff_00ff);
      host.wr(OFS_INT_ENABLE, en);
      host.rd(OFS_INT_ENABLE, d);
      check(d, en);
      @(posedge clk);
      lv_a <= 9'(thr[31:24]) + 9'($urandom_range(2)) - 9'h001;
      lv_b <= 9'(thr[23:16]) + 9'($urandom_range(2)) - 9'h001;
      lv_c <= 9'(thr[7:0]) + 9'($urandom_range(2)) - 9'h001;
      repeat (4) @(posedge clk);
      host.wr(OFS_INT_STATUS, 32'hffff_ffff);
      repeat (3) @(posedge clk);
      host.rd(OFS_INT_STATUS, d);
      check(d, lvl_sts(thr));
      check({31'h0, irq}, {31'h0, |(lvl_sts(thr) & en)});
    end
    $display("level thresholds done");
    @(posedge clk);
    {lv_a, lv_b, lv_c} <= 27'h0;
    host.wr(OFS_INT_ENABLE, IRQ_IMPL_MASK);
    repeat (3) @(posedge clk);
    host.wr(OFS_INT_STATUS, 32'hffff_ffff);
    host.wr(OFS_RX_READOUT, 32'h0003_0000);
    dwords(1, 1'b0);
    host.rd(OFS_RX_READOUT, d);
    check(d, 32'h0002_0000);
    host.wr(OFS_RX_READOUT, 32'h0002_0000);
    dwords(1, 1'b0);
    host.rd(OFS_INT_STATUS, d);
    check(d, 32'h0000_0000);
    dwords(2, 1'b0);
    host.rd(OFS_RX_READOUT, d);
    check(d, 32'h0000_0000);
    host.rd(OFS_INT_STATUS, d);
    check(d, 32'h0010_0000);
    check({31'h0, irq}, 32'h0000_0001);
    host.wr(OFS_INT_STATUS, 32'hffff_ffff);
    $display("countdown done");
    for (int a = 0; a < 4; a++)
      for (int j = 0; j < 3; j++)
      begin
        n = (j == 0) ? 8 : (j == 1) ? 1 : $urandom_range(12, 1);
        host.wr(OFS_RX_READOUT, {2'(a), 30'h0});
        @(posedge clk);
        pkt <= 1'b1;
        @(posedge clk);
        pkt <= 1'b0;
        dwords(n, 1'b1);
        #1;
        check({28'h0, pad_v, pad}, {28'h0, 1'b1, pad_exp(a, n)});
        @(posedge clk);
        #1;
        check({31'h0, pad_v}, 32'h0000_0000);
      end
    $display("end padding done");
    host.wr(OFS_RX_READOUT, 32'h0000_8000);
    #1;
    check({31'h0, disc}, 32'h0000_0001);
    @(posedge clk);
    #1;
    check({31'h0, disc}, 32'h0000_0000);
    host.rd(OFS_RX_READOUT, d);
    check(d, 32'h0000_0000);
    $display("discard done");
    for (int k = 0; k < 6; k++)
    begin
      w = $urandom & 32'hffff_7fff;
      host.wr(OFS_RX_READOUT, w);
      @(posedge clk);
      #1;
      check({30'h0, off_b}, {30'h0, w[9:8]});
      check({29'h0, off_dw}, {29'h0, prev_dw});
      host.rd(OFS_RX_READOUT, d);
      check(d, w & 32'hcfff_1f00);
      dwords(1, 1'b0);
      @(posedge clk);
      #1;
      check({29'h0, off_dw}, {29'h0, w[12:10]});
      prev_dw = w[12:10];
    end
    $display("offset done");
    tally_and_finish();
  end
endmodule
